// File: hdl/mccl_regs.vh
// Constants for the master card configuration loader
`ifndef MCCL_REGS_VH
`define MCCL_REGS_VH
`define MCCL_TAG_AUTH       8'h55
`define MCCL_TAG_SIGN       8'h56
`define MCCL_KEY_REC_LEN    8'h11
`define MCCL_FILE_CONFIG    8'h01
`define MCCL_FILE_SIGN      8'h02
`define MCCL_BLOCK_LEN      10'h200
`define MCCL_SIGN_LEN       5'h10
`define MCCL_MAX_VALUE      8'h18
`define MCCL_CHIPKEY_BASE   8'h80
`define MCCL_CHIPKEY_LEN    8'h06
`define MCCL_MODE_MSB       7
`define MCCL_MODE_LSB       6
`define MCCL_DIV_MSB        5
`define MCCL_DIV_LSB        4
`define MCCL_IDX_MSB        3
`define MCCL_IDX_LSB        0
`define MCCL_IDX_RESERVED   4'hf
`define MCCL_MODE_RESERVED  2'h2
`define MCCL_DIV_RESERVED   2'h3
`define MCCL_AUTH_OPT_RST   8'he0
`define MCCL_SIGN_OPT_RST   8'h20
`endif

// File: hdl/mccl_skid_buffer.v
// Two-entry buffer for the commit stream toward non-volatile storage
`timescale 1ns/10ps
module mccl_skid_buffer
#(
	parameter WIDTH = 8,
	parameter DEPTH = 2
)
(
	input  wire             clk_sys,   // System clock
	input  wire             sys_rst,   // Async reset, high
	input  wire [WIDTH-1:0] inData,    // Word in
	input  wire             inValid,   // Word offered
	output wire             inReady,   // Room available
	output wire [WIDTH-1:0] outData,   // Word out
	output wire             outValid,  // Word held
	input  wire             outReady   // Receiver takes word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg             wrPtr_reg;
	reg             rdPtr_reg;
	reg [1:0]       count_reg;
	wire            doWr = inValid && inReady;
	wire            doRd = outValid && outReady;

	assign inReady  = (count_reg != 2'h2);
	assign outValid = (count_reg != 2'h0);
	assign outData  = mem[rdPtr_reg];

	// Storage written without reset, pointers and count reset
	always @(posedge clk_sys)
	begin
		if (doWr)
			mem[wrPtr_reg] <= inData;
	end

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end
		else
		begin
			if (doWr)
				wrPtr_reg <= ~wrPtr_reg;
			if (doRd)
				rdPtr_reg <= ~rdPtr_reg;
			if (doWr && !doRd)
				count_reg <= count_reg + 2'h1;
			else if (doRd && !doWr)
				count_reg <= count_reg - 2'h1;
		end
	end
endmodule

// File: hdl/mccl_loader.v
// Master card configuration loader: key records, item parser, signature gate
// Summary of operation
// - Authentication record, tag 55, is option byte plus 16-byte key.
// - Auth option bits 7-6 pick read mode; 10 is reserved.
// - Key option bits 5-4 pick derivation; 11 is reserved.
// - Auth option bits 3-0 give key index; 1111 is reserved.
// - Signing record, tag 56, is option byte plus 128-bit key.
// - Block parsed as tag, length, value of up to 24 bytes.
// - Nonzero length item overwrites stored tag.
// - Zero length item deletes stored tag.
// - Tag 80 plus index with length 6 is a chip key.
// - Derive card key from signing key and UID, then hash block.
// - Hash spans all 512 bytes, padding included.
// - Configuration read from file 01, signature from file 02.
// - Nothing committed before the signature checks out.
`timescale 1ns/10ps
`include "mccl_regs.vh"
module mccl_loader
(
	input  wire         clk_sys,       // System clock, 25 MHz
	input  wire         sys_rst,       // Async reset, high
	input  wire         startLoad,     // Pulse: begin a master card load
	output reg          busy,          // Load in progress
	output reg          doneOk,        // Pulse: block committed
	output reg          errSignature,  // Sticky: signature mismatch
	output reg          errFormat,     // Sticky: bad item or record
	input  wire [7:0]   authOption,    // Stored auth option byte
	input  wire [7:0]   signOption,    // Stored signing option byte
	output wire [1:0]   readMode,      // Decoded card read mode
	output wire [1:0]   authDerive,    // Decoded auth derivation
	output wire [3:0]   authKeyIndex,  // Decoded auth key index
	output wire         authOptBad,    // Auth option uses reserved code
	output wire         signOptBad,    // Signing option not usable
	output reg          fileReq,       // Request a card file read
	output reg  [7:0]   fileId,        // File identifier requested
	input  wire         fileByteValid, // Byte from card file
	input  wire [7:0]   fileByte,      // Card file byte
	output wire         fileByteReady, // Loader accepts byte
	output reg          hashStart,     // Pulse: start derive plus hash
	output reg          hashByteValid, // Byte into hash core
	output reg  [7:0]   hashByte,      // Block byte to hash
	input  wire         hashDone,      // Hash core finished
	input  wire [127:0] hashResult,    // Computed signature
	output wire         nvmValid,      // Commit word offered
	output wire [24:0]  nvmWord,       // {op[1:0],kind,spare,index[4:0],tag,data}
	input  wire         nvmReady       // Storage takes word
);
	localparam S_IDLE = 7'h01, S_SIGN = 7'h02, S_CFG = 7'h04, S_WAIT = 7'h08;
	localparam S_APPLY = 7'h10, S_DONE = 7'h20, S_FAIL = 7'h40;
	localparam OP_WRITE = 2'h1, OP_DELETE = 2'h2, OP_END = 2'h3;

	reg [6:0]   state_reg;
	reg [127:0] sign_reg;
	reg [4:0]   signCnt_reg;
	reg [9:0]   byteCnt_reg;
	reg [7:0]   block [0:511];
	reg [9:0]   rdPtr_reg;
	reg [1:0]   phase_reg;     // 0 start, 1 tag, 2 length, 3 value
	reg [7:0]   tag_reg;
	reg [7:0]   len_reg;
	reg [4:0]   valCnt_reg;
	reg [7:0]   rdByte;
	reg         bufValid;
	reg [24:0]  bufData;
	wire        bufReady;

	// Option byte decode shared by both key records
	function [1:0] deriveField;
		input [7:0] opt;
		deriveField = opt[`MCCL_DIV_MSB:`MCCL_DIV_LSB];
	endfunction

	assign readMode     = authOption[`MCCL_MODE_MSB:`MCCL_MODE_LSB];
	assign authDerive   = deriveField(authOption);
	assign authKeyIndex = authOption[`MCCL_IDX_MSB:`MCCL_IDX_LSB];
	assign authOptBad   = (readMode == `MCCL_MODE_RESERVED) ||
	                      (authDerive == `MCCL_DIV_RESERVED) ||
	                      (authKeyIndex == `MCCL_IDX_RESERVED);
	// Signing key must use a defined derivation; stray bits flagged
	assign signOptBad   = (deriveField(signOption) == `MCCL_DIV_RESERVED) ||
	                      (signOption[7:6] != 2'h0) || (signOption[3:0] != 4'h0);

	assign fileByteReady = (state_reg == S_SIGN) || (state_reg == S_CFG);

	// Block memory, filled during the config file phase
	always @(posedge clk_sys)
	begin
		if (state_reg == S_CFG && fileByteValid)
			block[byteCnt_reg[8:0]] <= fileByte;
	end

	// Read without a pipeline stage so the byte always matches the pointer
	always @*
	begin
		rdByte = block[rdPtr_reg[8:0]];
	end

	// Parser emits one commit word per value byte or deleted tag; the buffer absorbs storage stalls
	always @*
	begin
		bufValid = 1'b0;
		bufData  = 25'h0;
		if (state_reg == S_APPLY && phase_reg == 2'h2 && len_reg == 8'h0)
		begin
			bufValid = 1'b1;
			bufData  = {OP_DELETE, 1'b0, 6'h0, tag_reg, 8'h0};
		end
		else if (state_reg == S_APPLY && phase_reg == 2'h3)
		begin
			bufValid = 1'b1;
			// Chip keys go to the secure key store, others to tag memory
			bufData  = {OP_WRITE,
			            (tag_reg[7:4] == 4'h8 && len_reg == `MCCL_CHIPKEY_LEN),
			            1'b0, valCnt_reg, tag_reg, rdByte};
		end
		else if (state_reg == S_DONE)
		begin
			bufValid = 1'b1;
			bufData  = {OP_END, 23'h0};
		end
	end

	mccl_skid_buffer #(.WIDTH(25), .DEPTH(2)) u_buf
	(
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.inData   (bufData),
		.inValid  (bufValid),
		.inReady  (bufReady),
		.outData  (nvmWord),
		.outValid (nvmValid),
		.outReady (nvmReady)
	);

	// Main sequencer: signature file, block file, hash, then apply
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg     <= S_IDLE;
			busy          <= 1'b0;
			doneOk        <= 1'b0;
			errSignature  <= 1'b0;
			errFormat     <= 1'b0;
			fileReq       <= 1'b0;
			fileId        <= 8'h0;
			hashStart     <= 1'b0;
			hashByteValid <= 1'b0;
			hashByte      <= 8'h0;
			sign_reg      <= 128'h0;
			signCnt_reg   <= 5'h0;
			byteCnt_reg   <= 10'h0;
			rdPtr_reg     <= 10'h0;
			phase_reg     <= 2'h0;
			tag_reg       <= 8'h0;
			len_reg       <= 8'h0;
			valCnt_reg    <= 5'h0;
		end
		else
		begin
			doneOk        <= 1'b0;
			fileReq       <= 1'b0;
			hashStart     <= 1'b0;
			hashByteValid <= 1'b0;
			case (state_reg)
			S_IDLE:
				if (startLoad)
				begin
					busy         <= 1'b1;
					errSignature <= 1'b0;
					errFormat    <= signOptBad;
					fileReq      <= 1'b1;
					fileId       <= `MCCL_FILE_SIGN;
					signCnt_reg  <= 5'h0;
					state_reg    <= signOptBad ? S_FAIL : S_SIGN;
				end
			S_SIGN:
				if (fileByteValid)
				begin
					sign_reg    <= {sign_reg[119:0], fileByte};
					signCnt_reg <= signCnt_reg + 5'h1;
					// Exactly sixteen bytes taken from the signature file
					if (signCnt_reg == `MCCL_SIGN_LEN - 5'h1)
					begin
						fileReq     <= 1'b1;
						fileId      <= `MCCL_FILE_CONFIG;
						hashStart   <= 1'b1;
						byteCnt_reg <= 10'h0;
						state_reg   <= S_CFG;
					end
				end
			S_CFG:
				if (fileByteValid)
				begin
					// Every byte hashed, padding too
					hashByteValid <= 1'b1;
					hashByte      <= fileByte;
					byteCnt_reg   <= byteCnt_reg + 10'h1;
					if (byteCnt_reg == `MCCL_BLOCK_LEN - 10'h1)
						state_reg <= S_WAIT;
				end
			S_WAIT:
				if (hashDone)
				begin
					rdPtr_reg <= 10'h0;
					phase_reg <= 2'h0;
					// Mismatch leaves storage untouched
					if (hashResult == sign_reg)
						state_reg <= S_APPLY;
					else
					begin
						errSignature <= 1'b1;
						state_reg    <= S_FAIL;
					end
				end
			S_APPLY:
				if (bufReady || !bufValid)
				begin
					case (phase_reg)
					2'h0:
						phase_reg <= 2'h1;
					2'h1:
						begin
							tag_reg <= rdByte;
							// Zero tag or block end stops the walk
							if (rdByte == 8'h0 || rdPtr_reg >= `MCCL_BLOCK_LEN)
								state_reg <= S_DONE;
							else
							begin
								rdPtr_reg <= rdPtr_reg + 10'h1;
								phase_reg <= 2'h2;
								len_reg   <= 8'hff;
							end
						end
					2'h2:
						if (len_reg == 8'hff)
						begin
							len_reg    <= rdByte;
							valCnt_reg <= 5'h0;
							rdPtr_reg  <= rdPtr_reg + 10'h1;
							// Values above 24 bytes are malformed
							if (rdByte > `MCCL_MAX_VALUE)
							begin
								errFormat <= 1'b1;
								state_reg <= S_DONE;
							end
						end
						else if (len_reg == 8'h0)
							phase_reg <= 2'h1;
						else
							phase_reg <= 2'h3;
					default:
						begin
							// One value byte per accepted word; last one returns to tag
							valCnt_reg <= valCnt_reg + 5'h1;
							rdPtr_reg  <= rdPtr_reg + 10'h1;
							if ({3'h0, valCnt_reg} == len_reg - 8'h1)
								phase_reg <= 2'h1;
						end
					endcase
				end
			S_DONE:
				if (bufReady)
				begin
					doneOk    <= !errFormat;
					busy      <= 1'b0;
					state_reg <= S_IDLE;
				end
			S_FAIL:
				begin
					busy      <= 1'b0;
					state_reg <= S_IDLE;
				end
			default:
				state_reg <= S_IDLE;
			endcase
		end
	end
	// Key record widths for storage sizing; 17 bytes each
	wire [7:0] authRecLen = `MCCL_KEY_REC_LEN;
endmodule

// File: tb/mccl_loader_monitor.sv
// Checker for the loader's port behaviour
`timescale 1ns/10ps
module mccl_loader_monitor
(
	input wire         clk_sys,       // Clock
	input wire         sys_rst,       // Reset
	input wire         startLoad,     // Start pulse
	input wire         busy,          // Load running
	input wire         doneOk,        // Done pulse
	input wire         errSignature,  // Bad signature
	input wire [7:0]   authOption,    // Auth option
	input wire [7:0]   signOption,    // Sign option
	input wire [1:0]   readMode,      // Read mode
	input wire [1:0]   authDerive,    // Derivation
	input wire [3:0]   authKeyIndex,  // Key index
	input wire         authOptBad,    // Auth reserved
	input wire         signOptBad,    // Sign unusable
	input wire         fileReq,       // File request
	input wire [7:0]   fileId,        // File id
	input wire         hashStart,     // Hash start
	input wire         nvmValid,      // Commit valid
	input wire [24:0]  nvmWord,       // Commit word
	input wire         nvmReady       // Commit taken
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Signature file is fetched first, config file opens hashing
	property p_sigFirst; !busy && startLoad |=> fileReq && fileId == 8'h02; endproperty
	a_sigFirst: assert property (p_sigFirst) else $error("no signature fetch");
	property p_cfgHash; fileReq && fileId == 8'h01 |-> hashStart && busy; endproperty
	a_cfgHash: assert property (p_cfgHash) else $error("no hash start");
	property p_decode; {readMode, authDerive, authKeyIndex} == authOption; endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_authBad; authOptBad == (authOption[7:6] == 2'h2 ||
		authOption[5:4] == 2'h3 || authOption[3:0] == 4'hf); endproperty
	a_authBad: assert property (p_authBad) else $error("bad auth flag");
	property p_signBad; signOptBad == (signOption[5:4] == 2'h3 ||
		signOption[7:6] != 2'h0 || signOption[3:0] != 4'h0); endproperty
	a_signBad: assert property (p_signBad) else $error("bad sign flag");
	property p_noCommit; errSignature |-> !nvmValid && !doneOk; endproperty
	a_noCommit: assert property (p_noCommit) else $error("commit after bad sig");
	// Stalled words must not be lost or altered
	property p_hold; nvmValid && !nvmReady |=> nvmValid && $stable(nvmWord); endproperty
	a_hold: assert property (p_hold) else $error("commit word dropped");
	property p_done; doneOk |=> !doneOk ##1 !doneOk; endproperty
	a_done: assert property (p_done) else $error("done not a pulse");
endmodule
bind mccl_loader mccl_loader_monitor mon (.*);

// File: tb/mccl_card_model.sv
// Card file store: serves the signature or config file bytes
`timescale 1ns/10ps
module mccl_card_model
(
	input wire       clk_sys,        // Clock
	input wire       sys_rst,        // Reset
	input wire       fileReq,        // File request
	input wire [7:0] fileId,         // File id
	input wire       fileByteReady,  // Byte taken
	output reg       fileByteValid,  // Byte offered
	output reg [7:0] fileByte        // Byte
);
	reg [7:0] sig [0:15];
	reg [7:0] cfg [0:511];
	integer   left, pos;
	reg       isCfg, gap;
	// Every other cycle idle, so the loader sees a slow card
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst) begin fileByteValid <= 0; fileByte <= 8'h00; left = 0; gap = 0; end
		else if (fileReq) begin
			isCfg = fileId == 8'h01;
			left = isCfg ? 512 : (fileId == 8'h02 ? 16 : 0);
			pos = 0;
			fileByteValid <= 0;
		end else if (!fileByteValid || fileByteReady) begin
			if (fileByteValid) begin pos = pos + 1; left = left - 1; end
			gap = !gap;
			if (left > 0 && !gap) begin
				fileByteValid <= 1;
				fileByte <= isCfg ? cfg[pos] : sig[pos];
			end else begin fileByteValid <= 0; fileByte <= ~fileByte; end
		end
	end
endmodule

// File: tb/mccl_loader_tb.sv
// Self-checking bench for the master card loader
`timescale 1ns/10ps
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module mccl_loader_tb;
	reg clk_sys, sys_rst, startLoad, hashDone, nvmReady, lax, expOn, doneSeen;
	reg  [7:0]   authOption, signOption, fileByte, hashByte;
	reg  [127:0] hashVal, sigA;
	wire [1:0]   readMode, authDerive;
	wire [3:0]   authKeyIndex;
	wire [7:0]   fileId;
	wire [24:0]  nvmWord;
	wire busy, doneOk, errSignature, errFormat, authOptBad, signOptBad, fileReq;
	wire fileByteValid, fileByteReady, hashStart, hashByteValid, nvmValid;
	integer seed, fail_count, compares, p, i, hcnt;
	reg  [25:0]  e;
	reg          expBad;
	reg  [7:0]   hq [$];
	reg  [24:0]  nq [$];
	mccl_loader dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .startLoad(startLoad),
		.busy(busy), .doneOk(doneOk), .errSignature(errSignature), .errFormat(errFormat),
		.authOption(authOption), .signOption(signOption), .readMode(readMode),
		.authDerive(authDerive), .authKeyIndex(authKeyIndex), .authOptBad(authOptBad),
		.signOptBad(signOptBad), .fileReq(fileReq), .fileId(fileId),
		.fileByteValid(fileByteValid), .fileByte(fileByte), .fileByteReady(fileByteReady),
		.hashStart(hashStart), .hashByteValid(hashByteValid), .hashByte(hashByte),
		.hashDone(hashDone), .hashResult(hashVal), .nvmValid(nvmValid),
		.nvmWord(nvmWord), .nvmReady(nvmReady));
	mccl_card_model card (.clk_sys(clk_sys), .sys_rst(sys_rst), .fileReq(fileReq),
		.fileId(fileId), .fileByteReady(fileByteReady), .fileByteValid(fileByteValid),
		.fileByte(fileByte));
	always #20 clk_sys = ~clk_sys;
	// Hash core stand-in: done one cycle after the 512th byte
	always @(posedge clk_sys)
	begin
		hashDone <= 1'b0;
		if (hashStart) hcnt = 0;
		if (hashByteValid) hcnt = hcnt + 1;
		if (hashByteValid && hcnt == 512) hashDone <= 1'b1;
	end
	// Receiver stalls at random; results checked against the oldest note
	always @(posedge clk_sys)
	begin
		if (!sys_rst) nvmReady <= $random(seed);
		if (doneOk === 1'b1) doneSeen = 1;
		if (hashByteValid === 1'b1) begin
			e = hq.size() ? {18'h0, hq.pop_front()} : 26'h3ffffff;
			`CHK("hashByte", e, {18'h0, hashByte})
		end
		if (nvmValid === 1'b1 && nvmReady === 1'b1 && (nq.size() || !lax)) begin
			e = nq.size() ? {1'b0, nq.pop_front()} : 26'h3ffffff;
			`CHK("nvmWord", e, {1'b0, nvmWord})
		end
	end
	task end_sim;
		begin
			if (fail_count == 0 && compares > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	task fresh;
		begin
			for (p = 0; p < 512; p = p + 1) card.cfg[p] = 8'h00;
			p = 0;
		end
	endtask
	// Writes one item into the card file and notes its commit words
	task item(input [7:0] t, input integer len);
		integer k;
		reg [7:0] v;
		begin
			card.cfg[p] = t;
			card.cfg[p + 1] = len;
			p = p + 2;
			for (k = 0; k < len; k = k + 1) begin
				v = t + k + 8'h11;
				card.cfg[p] = v;
				p = p + 1;
				if (expOn) nq.push_back({2'h1, t[7:4] == 4'h8, 1'b0, k[4:0], t, v});
			end
			if (expOn && len == 0) nq.push_back({2'h2, 7'h0, t, 8'h00});
		end
	endtask
	// Runs a load; a second start mid-run must be ignored
	task load(input [127:0] s, input [127:0] h);
		integer n;
		begin
			for (n = 0; n < 16; n = n + 1) card.sig[n] = s[127 - 8 * n -: 8];
			for (n = 0; n < 512; n = n + 1) hq.push_back(card.cfg[n]);
			hashVal <= h;
			doneSeen = 0;
			startLoad <= 1;
			@(posedge clk_sys) startLoad <= 0;
			repeat (30) @(posedge clk_sys);
			startLoad <= 1;
			@(posedge clk_sys) startLoad <= 0;
			for (n = 0; busy !== 1'b0 && n < 9000; n = n + 1) @(posedge clk_sys);
			repeat (6) @(posedge clk_sys);
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		end_sim;
	end
	initial
	begin
		clk_sys = 0; sys_rst = 1; startLoad = 0; hashDone = 0; nvmReady = 0;
		authOption = 8'he0; signOption = 8'h20; hashVal = 0; seed = 15;
		fail_count = 0; compares = 0; lax = 0; expOn = 1; hcnt = 0;
		sigA = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 0;
		for (i = 0; i < 40; i = i + 1) begin
			@(posedge clk_sys) authOption <= i ? $random(seed) : 8'he0;
			signOption <= i ? $random(seed) : 8'h20;
			@(negedge clk_sys) `CHK("authKeyIndex", authOption[3:0], authKeyIndex)
			expBad = (authOption[7:6] == 2'h2) | (authOption[5:4] == 2'h3) | (&authOption[3:0]);
			`CHK("authOptBad", expBad, authOptBad)
			`CHK("readMode", authOption[7:6], readMode)
			`CHK("authDerive", authOption[5:4], authDerive)
			expBad = (signOption[5:4] == 2'h3) | (signOption[7:6] != 2'h0) | (|signOption[3:0]);
			`CHK("signOptBad", expBad, signOptBad)
		end
		@(posedge clk_sys) authOption <= 8'he0;
		signOption <= 8'h20;
		fresh; item(8'h60, 2); item(8'h61, 0); item(8'h83, 6); item(8'haa, 16);
		nq.push_back({2'h3, 23'h0});
		load(sigA, sigA);
		`CHK("doneOk", 1'b1, doneSeen)
		`CHK("nvmLeft", 0, nq.size())
		expOn = 0;
		load(sigA, ~sigA);
		`CHK("errSignature", 1'b1, errSignature)
		`CHK("doneOk", 1'b0, doneSeen)
		fresh; expOn = 1; lax = 1; item(8'h62, 1);
		expOn = 0; item(8'h63, 25);
		load(sigA, sigA);
		`CHK("errFormat", 1'b1, errFormat)
		`CHK("nvmLeft", 0, nq.size())
		end_sim;
	end
endmodule
